/* File: design/flp_top.sv */
/*
 Flash lock regions, security bit, general non-volatile bits, calibration
 bits, fast programming entry and boot recovery detection.
 Assumes a flash array that runs one operation per start pulse and answers
 with a done pulse, and external front ends for the serial and parallel
 fast programming ports merged onto one command port.
*/
`include "flp_params.svh"
`default_nettype none
module flp_top #(
	parameter int unsigned BOOT_HOLD_CYCLES = `FLP_BOOT_HOLD_CYC
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic power_on_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o,
	input wire logic erase_pin_i,
	input wire logic test_mode_pin_i,
	input wire logic port_line_0_i,
	input wire logic port_line_1_i,
	input wire logic port_line_2_i,
	input wire logic dbg_req_i,
	output logic dbg_grant_o,
	input wire logic ffp_valid_i,
	input wire flp_pkg::flp_cmd_t ffp_cmd_i,
	input wire logic [`FLP_PAGE_W-1:0] ffp_page_i,
	output logic ffp_ready_o,
	output logic ffp_done_o,
	output logic ffp_error_o,
	output logic flash_start_o,
	output flp_pkg::flp_op_t flash_op_o,
	output logic [`FLP_PAGE_W-1:0] flash_page_o,
	input wire logic flash_done_i,
	output logic bod_enable_o,
	output logic bod_reset_enable_o,
	output logic [7:0] calib_o,
	output logic fast_prog_mode_o,
	output logic boot_restore_o,
	output logic boot_recovered_o
);
	import flp_pkg::*;

	localparam int unsigned PIN_N = 5;
	localparam logic [31:0] BOOT_LAST = 32'(BOOT_HOLD_CYCLES - 1);

	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] sync_a;
	logic [PIN_N-1:0] sync_b;
	logic [PIN_N-1:0] sync_c;
	logic [PIN_N-1:0] pin_f;
	logic erase_f;
	logic erase_f_d;
	logic strap_ffp;
	logic strap_boot;
	logic [31:0] lock_bits;
	logic security;
	logic [1:0] gp_bits;
	logic [31:0] mode_reg;
	logic [31:0] status_ev;
	logic [31:0] status_rd;
	flp_state_t state;
	flp_cmd_t cur_cmd;
	flp_src_t cur_src;
	logic [`FLP_PAGE_W-1:0] cur_page;
	logic sw_cmd_wr;
	flp_cmd_t sw_cmd;
	logic [`FLP_PAGE_W-1:0] sw_page;
	logic ffp_take;
	logic erase_req;
	logic erase_take;
	logic [4:0] cur_region;
	logic region_locked;
	logic any_locked;
	logic is_flash_op;
	logic lock_abort;
	logic ffp_deny;
	logic ev_done;
	logic ev_lock_error_flag;
	logic ev_deny;
	logic [31:0] ev_set;
	logic [31:0] ev_clr;
	logic [31:0] boot_cnt;
	logic boot_fired;

	// Pin inputs through three flops, level taken when last two agree
	assign pin_raw = {port_line_2_i, port_line_1_i, port_line_0_i,
		test_mode_pin_i, erase_pin_i};

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
		end else begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_pin
			always_ff @(posedge sys_clk_i) begin
				if (reset_i) begin
					pin_f[gi] <= 1'b0;
				end else if (sync_b[gi] == sync_c[gi]) begin
					pin_f[gi] <= sync_c[gi];
				end
			end
		end
	endgenerate

	assign erase_f = pin_f[0];
	assign strap_ffp = pin_f[1] & pin_f[2] & pin_f[3] & ~pin_f[4];
	assign strap_boot = pin_f[1] & pin_f[2] & pin_f[3] & pin_f[4];

	// Erase pin edge; the long hold is left to the driving party
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			erase_f_d <= 1'b0;
		end else begin
			erase_f_d <= erase_f;
		end
	end

	// Pending full erase requested by the erase pin
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			erase_req <= 1'b0;
		end else if (erase_f & ~erase_f_d) begin
			erase_req <= 1'b1;
		end else if (erase_take) begin
			erase_req <= 1'b0;
		end
	end

	// Software register decode
	assign sw_cmd_wr = reg_wr_i && (reg_addr_i == `FLP_OFS_CMD);
	assign sw_cmd = flp_cmd_t'(reg_wdata_i[`FLP_CMD_LSB +: 4]);
	assign sw_page = reg_wdata_i[`FLP_ARG_LSB +: `FLP_PAGE_W];

	// Fast programming port only in fast programming mode and when idle
	assign ffp_ready_o = fast_prog_mode_o && (state == FLP_ST_IDLE)
		&& !erase_req;
	assign ffp_take = ffp_valid_i && ffp_ready_o;
	assign erase_take = (state == FLP_ST_IDLE) && erase_req;

	// Region lookup of the current page
	assign cur_region = 5'(cur_page >> `FLP_REGION_SHIFT);
	assign region_locked = lock_bits[cur_region];
	assign any_locked = |lock_bits;
	assign is_flash_op = (cur_cmd == FLP_CMD_PAGE_PROG)
		|| (cur_cmd == FLP_CMD_PAGE_ERASE)
		|| (cur_cmd == FLP_CMD_FULL_ERASE);
	assign lock_abort = (cur_src != FLP_SRC_PIN) && is_flash_op
		&& ((cur_cmd == FLP_CMD_FULL_ERASE) ? any_locked
		: region_locked);
	assign ffp_deny = (cur_src == FLP_SRC_FFP) && security;

	// Command sequencer
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state <= FLP_ST_IDLE;
			cur_cmd <= FLP_CMD_NONE;
			cur_src <= FLP_SRC_SW;
			cur_page <= '0;
		end else begin
			case (state)
				FLP_ST_IDLE: begin
					if (erase_take) begin
						cur_cmd <= FLP_CMD_FULL_ERASE;
						cur_src <= FLP_SRC_PIN;
						cur_page <= '0;
						state <= FLP_ST_ISSUE;
					end else if (ffp_take) begin
						cur_cmd <= ffp_cmd_i;
						cur_src <= FLP_SRC_FFP;
						cur_page <= ffp_page_i;
						state <= FLP_ST_ISSUE;
					end else if (sw_cmd_wr && sw_cmd != FLP_CMD_READ
						&& sw_cmd != FLP_CMD_NONE) begin
						cur_cmd <= sw_cmd;
						cur_src <= FLP_SRC_SW;
						cur_page <= sw_page;
						state <= FLP_ST_ISSUE;
					end
				end
				FLP_ST_ISSUE: begin
					if (ffp_deny || lock_abort) begin
						state <= FLP_ST_FINISH;
					end else if (is_flash_op || cur_cmd == FLP_CMD_READ) begin
						state <= FLP_ST_WAIT;
					end else begin
						state <= FLP_ST_FINISH;
					end
				end
				FLP_ST_WAIT: begin
					if (flash_done_i) begin
						state <= FLP_ST_FINISH;
					end
				end
				FLP_ST_FINISH: begin
					state <= FLP_ST_IDLE;
				end
				default: begin
					state <= FLP_ST_IDLE;
				end
			endcase
		end
	end

	// Flash operation start pulse and its operands
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			flash_start_o <= 1'b0;
			flash_op_o <= FLP_OP_READ;
			flash_page_o <= '0;
		end else begin
			flash_start_o <= (state == FLP_ST_ISSUE) && !ffp_deny
				&& !lock_abort && (is_flash_op || cur_cmd == FLP_CMD_READ);
			flash_page_o <= cur_page;
			case (cur_cmd)
				FLP_CMD_PAGE_PROG: flash_op_o <= FLP_OP_PROG;
				FLP_CMD_PAGE_ERASE: flash_op_o <= FLP_OP_PAGE_ERASE;
				FLP_CMD_FULL_ERASE: flash_op_o <= FLP_OP_FULL_ERASE;
				default: flash_op_o <= FLP_OP_READ;
			endcase
		end
	end

	// Lock bits: persistent, cleared at power on, by the erase pin or one region at a time by the clear lock command
	always_ff @(posedge sys_clk_i) begin
		if (power_on_i) begin
			lock_bits <= '0;
		end else if (erase_f) begin
			lock_bits <= '0;
		end else if (state == FLP_ST_ISSUE && !ffp_deny
			&& cur_region < 5'(`FLP_LOCK_COUNT)) begin
			if (cur_cmd == FLP_CMD_SET_LOCK) begin
				lock_bits[cur_region] <= 1'b1;
			end else if (cur_cmd == FLP_CMD_CLR_LOCK) begin
				lock_bits[cur_region] <= 1'b0;
			end
		end
	end

	// Security bit: set by command only, cleared after pin driven erase
	always_ff @(posedge sys_clk_i) begin
		if (power_on_i) begin
			security <= 1'b0;
		end else if (state == FLP_ST_WAIT && flash_done_i
			&& cur_src == FLP_SRC_PIN) begin
			security <= 1'b0;
		end else if (state == FLP_ST_ISSUE && cur_cmd == FLP_CMD_SET_SEC
			&& !ffp_deny) begin
			security <= 1'b1;
		end
	end

	// General purpose bits steering the brownout logic
	always_ff @(posedge sys_clk_i) begin
		if (power_on_i) begin
			gp_bits <= '0;
		end else if (erase_f) begin
			gp_bits <= '0;
		end else if (state == FLP_ST_ISSUE && !ffp_deny
			&& cur_page < `FLP_PAGE_W'(2)) begin
			if (cur_cmd == FLP_CMD_SET_GP) begin
				gp_bits[cur_page[0]] <= 1'b1;
			end else if (cur_cmd == FLP_CMD_CLR_GP) begin
				gp_bits[cur_page[0]] <= 1'b0;
			end
		end
	end

	assign bod_enable_o = gp_bits[0];
	assign bod_reset_enable_o = gp_bits[1];
	assign calib_o = `FLP_CALIB_VALUE;

	// Debug port granted only while unsecured
	assign dbg_grant_o = dbg_req_i && !security;

	// Fast programming mode follows the straps
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			fast_prog_mode_o <= 1'b0;
		end else begin
			fast_prog_mode_o <= strap_ffp;
		end
	end

	// Fast programming answer
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ffp_done_o <= 1'b0;
			ffp_error_o <= 1'b0;
		end else begin
			ffp_done_o <= (state == FLP_ST_FINISH) && (cur_src == FLP_SRC_FFP);
			ffp_error_o <= (state == FLP_ST_ISSUE) && (cur_src == FLP_SRC_FFP)
				&& (ffp_deny || lock_abort) ? 1'b1
				: (state == FLP_ST_IDLE) ? 1'b0 : ffp_error_o;
		end
	end

	// Boot recovery hold counter, fires once until power on
	always_ff @(posedge sys_clk_i) begin
		if (power_on_i) begin
			boot_cnt <= '0;
			boot_fired <= 1'b0;
			boot_restore_o <= 1'b0;
		end else begin
			boot_restore_o <= 1'b0;
			if (!strap_boot) begin
				boot_cnt <= '0;
			end else if (!boot_fired) begin
				if (boot_cnt == BOOT_LAST) begin
					boot_fired <= 1'b1;
					boot_restore_o <= 1'b1;
				end else begin
					boot_cnt <= boot_cnt + 32'h1;
				end
			end
		end
	end

	assign boot_recovered_o = boot_fired;

	// Events into sticky status
	assign ev_done = (state == FLP_ST_FINISH);
	assign ev_lock_error_flag = (state == FLP_ST_ISSUE) && lock_abort && !ffp_deny;
	assign ev_deny = (state == FLP_ST_ISSUE) && ffp_deny;
	assign ev_set = {28'h0, ev_deny, ev_lock_error_flag, 1'b0, ev_done};
	assign ev_clr = (reg_wr_i && reg_addr_i == `FLP_OFS_STATUS)
		? (reg_wdata_i & `FLP_EV_MASK) : 32'h0;

	// Sticky flags, a new event beats a same cycle clear
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			status_ev <= '0;
		end else begin
			status_ev <= ev_set | (status_ev & ~ev_clr);
		end
	end

	// Mode register holds the interrupt enables
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mode_reg <= '0;
		end else if (reg_wr_i && reg_addr_i == `FLP_OFS_MODE) begin
			mode_reg <= reg_wdata_i & `FLP_EV_MASK;
		end
	end

	// Level interrupt from enabled flags
	assign irq_o = |(status_ev & mode_reg);

	assign status_rd = status_ev
		| {27'h0, (state != FLP_ST_IDLE), 4'h0};

	// Read data one cycle after the strobe
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`FLP_OFS_MODE: reg_rdata_o <= mode_reg;
				`FLP_OFS_STATUS: reg_rdata_o <= status_rd;
				`FLP_OFS_LOCKS: reg_rdata_o <= lock_bits;
				`FLP_OFS_NV: reg_rdata_o <= {16'h0, calib_o, 2'b00,
					boot_fired, fast_prog_mode_o, 1'b0, gp_bits, security};
				default: reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end
endmodule
`default_nettype wire

/* File: design/flp_params.svh */
/*
 Constants of the flash lock, security and non-volatile bit block.
 Assumes one clock of 10 MHz and inclusion by the top module and the bench.
*/
`ifndef FLP_PARAMS_SVH
`define FLP_PARAMS_SVH

`define FLP_CLK_HZ 10000000
`define FLP_LOCK_COUNT 16
`define FLP_REGION_SHIFT 6
`define FLP_PAGE_W 10
`define FLP_BOOT_HOLD_S 10
`define FLP_BOOT_HOLD_CYC (`FLP_BOOT_HOLD_S * `FLP_CLK_HZ)
`define FLP_CALIB_VALUE 8'h5a

// Register offsets
`define FLP_OFS_MODE 8'h00
`define FLP_OFS_CMD 8'h04
`define FLP_OFS_STATUS 8'h08
`define FLP_OFS_LOCKS 8'h0c
`define FLP_OFS_NV 8'h10

// Status and mode bit positions
`define FLP_BIT_DONE 0
`define FLP_BIT_LOCK_ERROR_FLAG 2
`define FLP_BIT_DENY 3
`define FLP_BIT_BUSY 4
`define FLP_EV_MASK 32'h0000000d

// Command word fields
`define FLP_CMD_LSB 0
`define FLP_ARG_LSB 8

// Non-volatile view fields
`define FLP_NV_SEC 0
`define FLP_NV_GP_LSB 1
`define FLP_NV_FFP 4
`define FLP_NV_BOOT 5
`define FLP_NV_CAL_LSB 8

`endif

/* File: design/flp_pkg.sv */
/*
 Types of the flash lock, security and non-volatile bit block.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none
package flp_pkg;
	typedef enum logic [3:0] {
		FLP_CMD_NONE = 4'h0,
		FLP_CMD_READ = 4'h1,
		FLP_CMD_PAGE_PROG = 4'h2,
		FLP_CMD_PAGE_ERASE = 4'h3,
		FLP_CMD_FULL_ERASE = 4'h4,
		FLP_CMD_SET_LOCK = 4'h5,
		FLP_CMD_CLR_LOCK = 4'h6,
		FLP_CMD_SET_SEC = 4'h7,
		FLP_CMD_SET_GP = 4'h8,
		FLP_CMD_CLR_GP = 4'h9
	} flp_cmd_t;

	typedef enum logic [1:0] {
		FLP_OP_READ = 2'h0,
		FLP_OP_PROG = 2'h1,
		FLP_OP_PAGE_ERASE = 2'h2,
		FLP_OP_FULL_ERASE = 2'h3
	} flp_op_t;

	// Gray ordered along idle, issue, wait, finish
	typedef enum logic [1:0] {
		FLP_ST_IDLE = 2'b00,
		FLP_ST_ISSUE = 2'b01,
		FLP_ST_WAIT = 2'b11,
		FLP_ST_FINISH = 2'b10
	} flp_state_t;

	typedef enum logic [1:0] {
		FLP_SRC_SW = 2'h0,
		FLP_SRC_FFP = 2'h1,
		FLP_SRC_PIN = 2'h2
	} flp_src_t;
endpackage
`default_nettype wire

/* File: dv/flp_top_properties.sv */
/*
 Port checker of the flash lock, security and general bit block.
 Assumes a bind into flp_top, one clock and a synchronous reset.
*/
`default_nettype none
module flp_top_props #(
	parameter int unsigned BOOT_HOLD_CYCLES = 50
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic power_on_i,
	input wire logic reg_wr_i,
	input wire logic erase_pin_i,
	input wire logic test_mode_pin_i,
	input wire logic port_line_0_i,
	input wire logic port_line_1_i,
	input wire logic port_line_2_i,
	input wire logic dbg_req_i,
	input wire logic dbg_grant_o,
	input wire logic ffp_valid_i,
	input wire logic ffp_done_o,
	input wire logic ffp_error_o,
	input wire logic flash_start_o,
	input wire logic bod_enable_o,
	input wire logic bod_reset_enable_o,
	input wire logic [7:0] calib_o,
	input wire logic fast_prog_mode_o,
	input wire logic boot_restore_o,
	input wire logic boot_recovered_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic straps_fp;
	logic straps_all;
	logic [31:0] hold_cnt;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	// Strap decodes
	assign straps_fp = test_mode_pin_i & port_line_0_i & port_line_1_i
		& !port_line_2_i;
	assign straps_all = test_mode_pin_i & port_line_0_i & port_line_1_i
		& port_line_2_i;

	// Cycles with every strap high, cleared like the boot counter
	always_ff @(posedge sys_clk_i) begin
		if (power_on_i || !straps_all)
			hold_cnt <= 32'h0;
		else if (hold_cnt != 32'hffffffff)
			hold_cnt <= hold_cnt + 32'h1;
	end

	calib_fixed_a: assert property (calib_o == 8'h5a)
		else $error("calibration bits changed");
	debug_gate_a: assert property (dbg_grant_o |-> dbg_req_i)
		else $error("debug grant without request");
	start_pulse_a: assert property (flash_start_o |=> !flash_start_o)
		else $error("flash start longer than one cycle");
	done_pulse_a: assert property (ffp_done_o |=> !ffp_done_o)
		else $error("fast programming done longer than one cycle");
	refused_idle_a: assert property (ffp_error_o |-> !flash_start_o)
		else $error("refused command started the flash");
	gp_hold_a: assert property (disable iff (reset_i || power_on_i)
		(!reg_wr_i && !ffp_valid_i && !erase_pin_i && !$past(power_on_i))[*3]
		|=> $stable({bod_enable_o, bod_reset_enable_o}))
		else $error("general bits changed without a command");
	erase_gp_a: assert property (erase_pin_i[*8]
		|-> !bod_enable_o && !bod_reset_enable_o)
		else $error("general bits survive the erase pin");
	fp_enter_a: assert property (straps_fp[*8] |-> fast_prog_mode_o)
		else $error("fast programming mode not entered");
	fp_leave_a: assert property ((!straps_fp)[*8]
		|-> !fast_prog_mode_o)
		else $error("fast programming mode without straps");
	boot_once_a: assert property (boot_restore_o
		|=> !boot_restore_o && boot_recovered_o)
		else $error("boot restore pulse malformed");
	boot_hold_a: assert property (boot_restore_o
		|-> hold_cnt >= BOOT_HOLD_CYCLES)
		else $error("boot restore before the hold time");
endmodule

bind flp_top flp_top_props #(.BOOT_HOLD_CYCLES(BOOT_HOLD_CYCLES)) i_props (
	.sys_clk_i(sys_clk_i), .reset_i(reset_i), .power_on_i(power_on_i),
	.reg_wr_i(reg_wr_i), .erase_pin_i(erase_pin_i),
	.test_mode_pin_i(test_mode_pin_i), .port_line_0_i(port_line_0_i),
	.port_line_1_i(port_line_1_i), .port_line_2_i(port_line_2_i),
	.dbg_req_i(dbg_req_i), .dbg_grant_o(dbg_grant_o),
	.ffp_valid_i(ffp_valid_i), .ffp_done_o(ffp_done_o),
	.ffp_error_o(ffp_error_o), .flash_start_o(flash_start_o),
	.bod_enable_o(bod_enable_o), .bod_reset_enable_o(bod_reset_enable_o),
	.calib_o(calib_o), .fast_prog_mode_o(fast_prog_mode_o),
	.boot_restore_o(boot_restore_o), .boot_recovered_o(boot_recovered_o)
);
`default_nettype wire

/* File: dv/flp_flash_model.sv */
/*
 Behavioural flash array: answers each start with one done pulse.
 Assumes start pulses one cycle long, never while an operation runs.
*/
`default_nettype none
module flp_flash_model #(
	parameter int DELAY = 6
) (
	input wire logic sys_clk_i,
	input wire logic flash_start_i,
	output logic flash_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;

	// Done ends every operation, the pin full erase included
	always @(posedge sys_clk_i) begin
		flash_done_o <= (cnt == 1);
		if (flash_start_i === 1'b1)
			cnt <= DELAY;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule
`default_nettype wire

/* File: dv/flp_top_tb.sv */
/*
 Self-checking bench of the lock, security and general bit block.
 Assumes the flash model as far side and a shortened boot hold count.
*/
`include "flp_params.svh"
`default_nettype none
module flp_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import flp_pkg::*;
	logic sys_clk_i, reset_i = 1, power_on_i = 1, reg_wr_i = 0, reg_rd_i = 0;
	logic [7:0] reg_addr_i = 8'h0;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
	logic erase_pin_i = 0, test_mode_pin_i = 0, dbg_req_i = 0, ffp_valid_i = 0;
	logic port_line_0_i = 0, port_line_1_i = 0, port_line_2_i = 0;
	flp_cmd_t ffp_cmd_i = FLP_CMD_NONE;
	flp_op_t flash_op_o;
	logic [9:0] ffp_page_i = 10'h0, flash_page_o;
	logic [7:0] calib_o;
	logic irq_o, dbg_grant_o, ffp_ready_o, ffp_done_o, ffp_error_o;
	logic flash_start_o, flash_done_i, bod_enable_o, bod_reset_enable_o;
	logic fast_prog_mode_o, boot_restore_o, boot_recovered_o;
	int n_errors = 0, num_checks = 0, cycles = 0, n_starts = 0, n_boot = 0;
	flp_op_t last_op = FLP_OP_READ;
	logic [9:0] last_page = 10'h0;
	flp_cmd_t ops[6] = '{FLP_CMD_READ, FLP_CMD_PAGE_PROG, FLP_CMD_PAGE_ERASE,
		FLP_CMD_FULL_ERASE, FLP_CMD_SET_LOCK, FLP_CMD_CLR_LOCK};

	flp_top #(.BOOT_HOLD_CYCLES(50)) i_dut (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .power_on_i(power_on_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .erase_pin_i(erase_pin_i),
		.test_mode_pin_i(test_mode_pin_i), .port_line_0_i(port_line_0_i),
		.port_line_1_i(port_line_1_i), .port_line_2_i(port_line_2_i),
		.dbg_req_i(dbg_req_i), .dbg_grant_o(dbg_grant_o),
		.ffp_valid_i(ffp_valid_i), .ffp_cmd_i(ffp_cmd_i),
		.ffp_page_i(ffp_page_i), .ffp_ready_o(ffp_ready_o),
		.ffp_done_o(ffp_done_o), .ffp_error_o(ffp_error_o),
		.flash_start_o(flash_start_o), .flash_op_o(flash_op_o),
		.flash_page_o(flash_page_o), .flash_done_i(flash_done_i),
		.bod_enable_o(bod_enable_o), .bod_reset_enable_o(bod_reset_enable_o),
		.calib_o(calib_o), .fast_prog_mode_o(fast_prog_mode_o),
		.boot_restore_o(boot_restore_o), .boot_recovered_o(boot_recovered_o));
	flp_flash_model i_flash (.sys_clk_i(sys_clk_i),
		.flash_start_i(flash_start_o), .flash_done_o(flash_done_i));

	// Clock of 100 ns
	initial begin
		sys_clk_i = 0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	// Cycle ceiling, flash start count with its operands, boot pulses
	always @(posedge sys_clk_i) begin
		cycles++;
		if (flash_start_o === 1'b1) begin
			n_starts++;
			last_op = flash_op_o;
			last_page = flash_page_o;
		end
		if (boot_restore_o === 1'b1)
			n_boot++;
		if (cycles == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o & m, e);
	endtask

	// Command write; callers wait out the sequencer afterwards
	task automatic cmd(input logic [3:0] c, input logic [9:0] p);
		wr(`FLP_OFS_CMD, {14'h0, p, 4'h0, c});
	endtask

	task automatic ffp(input flp_cmd_t c, input logic [9:0] p,
		output logic err);
		int i;
		err = 1'b0;
		@(posedge sys_clk_i);
		ffp_valid_i <= 1'b1;
		ffp_cmd_i <= c;
		ffp_page_i <= p;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk_i);
			if (ffp_ready_o === 1'b1)
				break;
		end
		ffp_valid_i <= 1'b0;
		for (i = 0; i < 50 && ffp_done_o !== 1'b1; i++) begin
			@(posedge sys_clk_i);
			#1 err = err | (ffp_error_o === 1'b1);
		end
	endtask

	task automatic straps(input logic [3:0] v);
		@(posedge sys_clk_i);
		{test_mode_pin_i, port_line_0_i, port_line_1_i, port_line_2_i} <= v;
		repeat (10) @(posedge sys_clk_i);
		#1;
	endtask

	// Main sequence
	initial begin
		int i;
		logic e;
		repeat (12) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		power_on_i <= 1'b0;
		rchk(`FLP_OFS_NV, 32'hff01, 32'h5a00);
		wr(`FLP_OFS_STATUS, 32'hd);
		cmd(4'h5, 10'h040);
		repeat (20) @(posedge sys_clk_i);
		rchk(`FLP_OFS_LOCKS, 32'hffff, 32'h2);
		i = n_starts;
		cmd(4'h2, 10'h03f);
		repeat (20) @(posedge sys_clk_i);
		chk(32'(n_starts - i), 32'h1);
		chk(32'(last_op), 32'(FLP_OP_PROG));
		chk(32'(last_page), 32'h3f);
		rchk(`FLP_OFS_STATUS, 32'h4, 32'h0);
		cmd(4'h2, 10'h07f);
		repeat (20) @(posedge sys_clk_i);
		chk(32'(n_starts - i), 32'h1);
		rchk(`FLP_OFS_STATUS, 32'h4, 32'h4);
		chk(32'(irq_o), 32'h0);
		wr(`FLP_OFS_MODE, 32'h4);
		chk(32'(irq_o), 32'h1);
		wr(`FLP_OFS_STATUS, 32'h4);
		chk(32'(irq_o), 32'h0);
		cmd(4'h6, 10'h040);
		repeat (20) @(posedge sys_clk_i);
		rchk(`FLP_OFS_LOCKS, 32'hffff, 32'h0);
		for (i = 0; i < 3; i++) begin
			cmd(i == 2 ? 4'h9 : 4'h8, i == 1 ? 10'h1 : 10'h0);
			repeat (20) @(posedge sys_clk_i);
		end
		chk(32'({bod_reset_enable_o, bod_enable_o}), 32'h2);
		rchk(`FLP_OFS_NV, 32'h6, 32'h4);
		cmd(4'h5, 10'h0c0);
		repeat (20) @(posedge sys_clk_i);
		i = n_starts;
		cmd(4'h4, 10'h0);
		repeat (20) @(posedge sys_clk_i);
		chk(32'(n_starts - i), 32'h0);
		rchk(`FLP_OFS_STATUS, 32'h4, 32'h4);
		chk(32'(irq_o), 32'h1);
		cmd(4'h7, 10'h0);
		repeat (20) @(posedge sys_clk_i);
		dbg_req_i <= 1'b1;
		@(posedge sys_clk_i);
		#1 chk(32'(dbg_grant_o), 32'h0);
		straps(4'he);
		chk(32'(fast_prog_mode_o), 32'h1);
		ffp(FLP_CMD_READ, 10'h0, e);
		chk(32'(e), 32'h1);
		rchk(`FLP_OFS_STATUS, 32'h8, 32'h8);
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		@(posedge sys_clk_i);
		reset_i <= 1'b0;
		rchk(`FLP_OFS_NV, 32'h1, 32'h1);
		rchk(`FLP_OFS_LOCKS, 32'hffff, 32'h8);
		straps(4'h0);
		// Erase pin held for a shortened time
		erase_pin_i <= 1'b1;
		repeat (40) @(posedge sys_clk_i);
		erase_pin_i <= 1'b0;
		repeat (40) @(posedge sys_clk_i);
		rchk(`FLP_OFS_LOCKS, 32'hffff, 32'h0);
		rchk(`FLP_OFS_NV, 32'hff07, 32'h5a00);
		chk(32'(dbg_grant_o), 32'h1);
		chk(32'(last_op), 32'(FLP_OP_FULL_ERASE));
		straps(4'he);
		for (i = 0; i < 6; i++) begin
			ffp(ops[i], 10'h0, e);
			chk(32'(e), 32'h0);
		end
		rchk(`FLP_OFS_LOCKS, 32'hffff, 32'h0);
		ffp(FLP_CMD_SET_SEC, 10'h0, e);
		rchk(`FLP_OFS_NV, 32'h1, 32'h1);
		straps(4'hf);
		repeat (70) @(posedge sys_clk_i);
		#1 chk(32'(boot_recovered_o), 32'h1);
		chk(32'(n_boot), 32'h1);
		chk(32'(fast_prog_mode_o), 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
